/* File: uic_core_model.sv */
// Behavioural core sequencer with its program stack
`timescale 1ns/1ps
module uic_core_model (
   // Clock and reset
   input  wire logic           sys_clk,
   input  wire logic           nrst,
   // From the controller and bench
   input  wire logic           seqBusy,
   input  wire logic           stackPush,
   input  wire logic           retReq,
   // To the controller
   output logic                instrLast,
   output logic [12:0]         pcNow,
   output logic                carryFlag,
   output logic                zeroFlag,
   output logic                returnFromIrqInstr,
   output uic_pkg::uic_frame_t stackPopFrame,
   // To the bench
   output uic_pkg::uic_frame_t ackFrame,
   output uic_pkg::uic_frame_t lastPop
);
   // ==================================================================
   // Instructions of 1 to 4 cycles, frozen while the call sequence runs
   uic_pkg::uic_frame_t stk[$];
   logic [2:0]          cnt;

   assign instrLast = (cnt == 3'h0) && !seqBusy;
   assign carryFlag = pcNow[0];
   assign zeroFlag  = ~pcNow[1];

   always @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         cnt                <= 3'h0;
         pcNow              <= 13'h0100;
         returnFromIrqInstr <= 1'b0;
         stackPopFrame      <= '0;
      end else begin
         if (!seqBusy) begin
            cnt   <= (cnt == 3'h0) ? {1'b0, pcNow[1:0]} : cnt - 3'h1;
            pcNow <= pcNow + ((cnt == 3'h0) ? 13'h0001 : 13'h0000);
         end
         ackFrame <= {pcNow, carryFlag, zeroFlag};
         if (stackPush) stk.push_back(ackFrame);
         returnFromIrqInstr <= retReq;
         // Popped word is only valid with the return pulse; garbage otherwise
         if (retReq) begin
            lastPop       <= stk[$];
            stackPopFrame <= stk.pop_back();
         end else begin
            stackPopFrame <= ~stackPopFrame;
         end
      end
   end
endmodule : uic_core_model

/* File: uic_irq_ctrl.sv */
// Interrupt controller: source latches, masks, vector call sequencer, APB registers
// ======================================================================
//
// The APB slave port was left to the implementer.
`timescale 1ns/1ps

module uic_irq_ctrl #(
   parameter int unsigned DAC_W = 8,
   parameter int unsigned GPIO_W = 32
) (
   // Clock and reset
   input  wire logic                 sys_clk,
   input  wire logic                 nrst,
   // APB slave
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [11:0]          paddr,
   input  wire logic [31:0]          pwdata,
   output logic      [31:0]          prdata,
   output logic                      pready,
   output logic                      pslverr,
   // Interrupt sources
   input  wire logic                 usbDp,
   input  wire logic                 usbDm,
   input  wire logic                 tick128us,
   input  wire logic                 tick1024us,
   input  wire logic [2:0]           epPacketDone,
   input  wire logic [DAC_W-1:0]     dacPins,
   input  wire logic [GPIO_W-1:0]    gpioPins,
   // Core sequencer
   input  wire logic                 instrLast,
   input  wire logic                 enableIrqsInstr,
   input  wire logic                 disableIrqsInstr,
   input  wire logic                 returnFromIrqInstr,
   input  wire logic [12:0]          pcNow,
   input  wire logic                 carryFlag,
   input  wire logic                 zeroFlag,
   input  wire uic_pkg::uic_frame_t  stackPopFrame,
   output logic                      seqBusy,
   output logic                      stackPush,
   output uic_pkg::uic_frame_t       stackPushFrame,
   output logic      [12:0]          fetchAddr,
   output logic                      fetchLoad,
   output logic                      handlerStart,
   output logic                      restoreValid,
   output uic_pkg::uic_frame_t       restoreFrame,
   output logic                      irqEnabled
);

   // ===================================================================
   // Declarations
   logic [uic_pkg::GIE_W-1:0]   globalIe_ff;
   logic [uic_pkg::EP_IE_W-1:0] epIe_ff;
   logic [31:0]                 pinIe_ff   [2];
   logic [31:0]                 pinPol_ff  [2];
   logic [31:0]                 pinAct_ff  [2];
   logic [31:0]                 pinLock_ff [2];
   logic [31:0]                 grpPins    [2];
   logic [31:0]                 grpPol     [2];
   logic [1:0]                  grpEvent;
   logic [uic_pkg::VEC_N-1:0]   pending_ff;
   logic [uic_pkg::VEC_N-1:0]   srcEvent;
   logic [uic_pkg::VEC_N-1:0]   srcMask;
   logic [uic_pkg::VEC_N-1:0]   pendEff;
   logic                        ie_ff;
   logic                        irqPend_ff;
   logic                        busRstFlag_ff;
   logic [10:0]                 se0Cnt_ff;
   logic                        busRstEvent;
   uic_pkg::uic_seq_t           seq_ff;
   logic [3:0]                  seqCnt_ff;
   logic [3:0]                  selVec;
   logic                        ackNow;
   logic [12:0]                 vecAddr_ff;
   logic                        wrEn;
   logic                        rdSetup;
   logic                        mapped;
   logic [31:0]                 rdData;

   function automatic logic [3:0] lowestSet(input logic [uic_pkg::VEC_N-1:0] v);
      lowestSet = 4'h0;
      for (int i = uic_pkg::VEC_N - 1; i >= 1; i--) begin
         if (v[i]) begin
            lowestSet = 4'(i);
         end
      end
   endfunction : lowestSet

   function automatic logic hit(input logic [11:0] a, input logic [7:0] idx);
      hit = (a == uic_pkg::regAddr(idx));
   endfunction : hit

   // ===================================================================
   // APB decode; zero wait states, unmapped addresses answer with error
   assign pready  = 1'b1;
   assign wrEn    = psel & penable & pwrite & mapped;
   assign rdSetup = psel & ~penable & ~pwrite;

   always_comb begin
      mapped = 1'b1;
      rdData = 32'h0000_0000;
      if (hit(paddr, uic_pkg::REG_GLOBAL_IE_IDX)) begin
         rdData = {27'h0000000, globalIe_ff};
      end else if (hit(paddr, uic_pkg::REG_EP_IE_IDX)) begin
         rdData = {29'h00000000, epIe_ff};
      end else if (hit(paddr, uic_pkg::REG_DAC_IE_IDX)) begin
         rdData = pinIe_ff[0];
      end else if (hit(paddr, uic_pkg::REG_DAC_POL_IDX)) begin
         rdData = pinPol_ff[0];
      end else if (hit(paddr, uic_pkg::REG_GPIO_IE_IDX)) begin
         rdData = pinIe_ff[1];
      end else if (hit(paddr, uic_pkg::REG_GPIO_POL_IDX)) begin
         rdData = pinPol_ff[1];
      end else if (hit(paddr, uic_pkg::REG_PENDING_IDX)) begin
         rdData = {20'h00000, pending_ff};
      end else if (hit(paddr, uic_pkg::REG_STATUS_IDX)) begin
         rdData = 32'h0000_0000;
         rdData[uic_pkg::STAT_PEND_BIT]   = irqPend_ff;
         rdData[uic_pkg::STAT_BUSRST_BIT] = busRstFlag_ff;
         rdData[uic_pkg::STAT_IE_BIT]     = ie_ff;
      end else begin
         mapped = 1'b0;
      end
   end

   assign pslverr = psel & penable & ~mapped;

   // Read data is captured in the setup phase so it stands for the access phase
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         prdata <= 32'h0000_0000;
      end else if (rdSetup) begin
         prdata <= rdData;
      end
   end

   // ===================================================================
   // Enable registers
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         globalIe_ff <= uic_pkg::GIE_RST;
         epIe_ff     <= uic_pkg::EP_IE_RST;
      end else if (wrEn) begin
         if (hit(paddr, uic_pkg::REG_GLOBAL_IE_IDX)) begin
            globalIe_ff <= pwdata[uic_pkg::GIE_W-1:0];
         end
         if (hit(paddr, uic_pkg::REG_EP_IE_IDX)) begin
            epIe_ff <= pwdata[uic_pkg::EP_IE_W-1:0];
         end
      end
   end

   // Group 0 is the DAC port, group 1 the GPIO ports; unused DAC bits stay zero
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         pinIe_ff[0]  <= uic_pkg::PIN_IE_RST;
         pinIe_ff[1]  <= uic_pkg::PIN_IE_RST;
         pinPol_ff[0] <= uic_pkg::PIN_POL_RST;
         pinPol_ff[1] <= uic_pkg::PIN_POL_RST;
      end else if (wrEn) begin
         if (hit(paddr, uic_pkg::REG_DAC_IE_IDX)) begin
            pinIe_ff[0] <= 32'(pwdata[DAC_W-1:0]);
         end
         if (hit(paddr, uic_pkg::REG_DAC_POL_IDX)) begin
            pinPol_ff[0] <= 32'(pwdata[DAC_W-1:0]);
         end
         if (hit(paddr, uic_pkg::REG_GPIO_IE_IDX)) begin
            pinIe_ff[1] <= 32'(pwdata[GPIO_W-1:0]);
         end
         if (hit(paddr, uic_pkg::REG_GPIO_POL_IDX)) begin
            pinPol_ff[1] <= {28'h0000000, pwdata[3:0]};
         end
      end
   end

   // Polarity is per pin on the DAC port and per 8-pin port on GPIO
   assign grpPins[0] = 32'(dacPins);
   assign grpPins[1] = 32'(gpioPins);
   assign grpPol[0]  = pinPol_ff[0];
   assign grpPol[1]  = {{8{pinPol_ff[1][3]}}, {8{pinPol_ff[1][2]}},
                        {8{pinPol_ff[1][1]}}, {8{pinPol_ff[1][0]}}};

   // ===================================================================
   // Pin edge detection with lockout
   for (genvar g = 0; g < 2; g++) begin : gPinGrp
      logic [31:0] act;
      logic [31:0] trig;
      assign act  = ~(grpPins[g] ^ grpPol[g]);
      assign trig = act & ~pinAct_ff[g] & pinIe_ff[g];
      // Any trigger while nothing is locked raises the shared request
      assign grpEvent[g] = (|trig) & ~(|pinLock_ff[g]);

      always_ff @(posedge sys_clk or negedge nrst) begin
         if (!nrst) begin
            pinAct_ff[g]  <= 32'h0000_0000;
            pinLock_ff[g] <= 32'h0000_0000;
         end else begin
            pinAct_ff[g] <= act;
            // Every pin that fired together holds the lock; no pin is preferred
            if (grpEvent[g]) begin
               pinLock_ff[g] <= trig;
            end else begin
               pinLock_ff[g] <= pinLock_ff[g] & act & pinIe_ff[g];
            end
         end
      end
   end

   // ===================================================================
   // USB bus reset detector: SE0 held longer than the minimum
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         se0Cnt_ff <= 11'h000;
      end else if (usbDp | usbDm) begin
         se0Cnt_ff <= 11'h000;
      end else if (se0Cnt_ff <= 11'(uic_pkg::BUSRST_CYC)) begin
         se0Cnt_ff <= se0Cnt_ff + 11'h001;
      end
   end

   // Fires once per SE0, on the first cycle beyond the minimum
   assign busRstEvent = ~usbDp & ~usbDm & (se0Cnt_ff == 11'(uic_pkg::BUSRST_CYC));

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         busRstFlag_ff <= 1'b0;
      end else if (busRstEvent) begin
         busRstFlag_ff <= 1'b1;
      end else if (wrEn && hit(paddr, uic_pkg::REG_STATUS_IDX)) begin
         busRstFlag_ff <= pwdata[uic_pkg::STAT_BUSRST_BIT];
      end
   end

   // ===================================================================
   // Source map by vector number
   always_comb begin
      srcEvent = '0;
      srcMask  = '0;
      srcEvent[uic_pkg::VN_BUSRST] = busRstEvent;
      srcEvent[uic_pkg::VN_T128]   = tick128us;
      srcEvent[uic_pkg::VN_T1024]  = tick1024us;
      srcEvent[uic_pkg::VN_EP0 +: 3] = epPacketDone;
      srcEvent[uic_pkg::VN_DAC]    = grpEvent[0];
      srcEvent[uic_pkg::VN_GPIO]   = grpEvent[1];
      srcMask[uic_pkg::VN_BUSRST]  = globalIe_ff[uic_pkg::GIE_BUSRST_BIT];
      srcMask[uic_pkg::VN_T128]    = globalIe_ff[uic_pkg::GIE_T128_BIT];
      srcMask[uic_pkg::VN_T1024]   = globalIe_ff[uic_pkg::GIE_T1024_BIT];
      srcMask[uic_pkg::VN_EP0 +: 3] = epIe_ff;
      srcMask[uic_pkg::VN_DAC]     = globalIe_ff[uic_pkg::GIE_DAC_BIT];
      srcMask[uic_pkg::VN_GPIO]    = globalIe_ff[uic_pkg::GIE_GPIO_BIT];
   end

   assign pendEff = pending_ff & srcMask;
   assign selVec  = lowestSet(pendEff);
   assign ackNow  = instrLast & ie_ff & (|pendEff) & (seq_ff == uic_pkg::SEQ_IDLE);

   // ===================================================================
   // Pending latches; a new event in the acknowledge cycle is kept
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         pending_ff <= '0;
      end else begin
         for (int i = 1; i < uic_pkg::VEC_N; i++) begin
            if (srcEvent[i] && srcMask[i]) begin
               pending_ff[i] <= 1'b1;
            end else if (ackNow && (selVec == 4'(i))) begin
               pending_ff[i] <= 1'b0;
            end
         end
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         irqPend_ff <= 1'b0;
      end else if ((|(pendEff & ~(ackNow ? (12'h001 << selVec) : 12'h000))) |
                   (|(srcEvent & srcMask))) begin
         irqPend_ff <= 1'b1;
      end else if (ackNow) begin
         irqPend_ff <= 1'b0;
      end
   end

   // ===================================================================
   // Global interrupt enable, changed only by instructions and acknowledge
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         ie_ff <= 1'b0;
      end else if (ackNow) begin
         ie_ff <= 1'b0;
      end else if (disableIrqsInstr) begin
         ie_ff <= 1'b0;
      end else if (enableIrqsInstr || returnFromIrqInstr) begin
         ie_ff <= 1'b1;
      end
   end

   assign irqEnabled = ie_ff;

   // ===================================================================
   // Vector call sequencer: call phase then table jump phase
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         seq_ff    <= uic_pkg::SEQ_IDLE;
         seqCnt_ff <= 4'h0;
      end else begin
         case (seq_ff)
            uic_pkg::SEQ_IDLE: begin
               if (ackNow) begin
                  seq_ff    <= uic_pkg::SEQ_CALL;
                  seqCnt_ff <= 4'(uic_pkg::CALL_CYC - 1);
               end
            end
            uic_pkg::SEQ_CALL: begin
               if (seqCnt_ff == 4'h0) begin
                  seq_ff    <= uic_pkg::SEQ_JUMP;
                  seqCnt_ff <= 4'(uic_pkg::JMP_CYC - 1);
               end else begin
                  seqCnt_ff <= seqCnt_ff - 4'h1;
               end
            end
            uic_pkg::SEQ_JUMP: begin
               if (seqCnt_ff == 4'h0) begin
                  seq_ff <= uic_pkg::SEQ_IDLE;
               end else begin
                  seqCnt_ff <= seqCnt_ff - 4'h1;
               end
            end
            default: begin
               seq_ff <= uic_pkg::SEQ_IDLE;
            end
         endcase
      end
   end

   assign seqBusy = (seq_ff != uic_pkg::SEQ_IDLE);

   // Stack frame push in the first cycle of the call; accumulator is not saved
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         stackPush      <= 1'b0;
         stackPushFrame <= '0;
         vecAddr_ff     <= uic_pkg::RESET_VECTOR;
      end else begin
         stackPush <= ackNow;
         if (ackNow) begin
            stackPushFrame <= '{pc: pcNow, carryFlag: carryFlag, zeroFlag: zeroFlag};
            vecAddr_ff     <= 13'(selVec) * 13'(uic_pkg::VEC_STRIDE);
         end
      end
   end

   // Fetch address shows the reset vector until the first call lands
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         fetchAddr    <= uic_pkg::RESET_VECTOR;
         fetchLoad    <= 1'b0;
         handlerStart <= 1'b0;
      end else begin
         fetchLoad    <= (seq_ff == uic_pkg::SEQ_CALL) && (seqCnt_ff == 4'h0);
         handlerStart <= (seq_ff == uic_pkg::SEQ_JUMP) && (seqCnt_ff == 4'h0);
         if ((seq_ff == uic_pkg::SEQ_CALL) && (seqCnt_ff == 4'h0)) begin
            fetchAddr <= vecAddr_ff;
         end
      end
   end

   // ===================================================================
   // Return from interrupt: restore frame one cycle after the instruction
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         restoreValid <= 1'b0;
         restoreFrame <= '0;
      end else begin
         restoreValid <= returnFromIrqInstr;
         if (returnFromIrqInstr) begin
            restoreFrame <= stackPopFrame;
         end
      end
   end

endmodule : uic_irq_ctrl

/* File: uic_irq_ctrl_sva.sv */
// Port-level assertions for the interrupt controller
`timescale 1ns/1ps
module uic_irq_ctrl_sva (
   // Clock and reset
   input wire logic        sys_clk,
   input wire logic        nrst,
   // Core sequencer side
   input wire logic        instrLast,
   input wire logic        enableIrqsInstr,
   input wire logic        returnFromIrqInstr,
   input wire logic        seqBusy,
   input wire logic        stackPush,
   input wire logic [12:0] fetchAddr,
   input wire logic        fetchLoad,
   input wire logic        handlerStart,
   input wire logic        restoreValid,
   input wire logic        irqEnabled
);
   // ==================================================================
   // Acknowledge, vector call, return and enable instruction
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);

   ack_at_last_a: assert property ($rose(seqBusy) |-> $past(instrLast))
      else $error("acknowledge taken outside the last instruction cycle");
   push_on_ack_a: assert property ($rose(seqBusy) |-> stackPush)
      else $error("no stack push with the acknowledge");
   ie_cleared_a: assert property (stackPush |-> !irqEnabled)
      else $error("global enable still set during the call");
   call_time_a: assert property (stackPush |-> ##10 fetchLoad)
      else $error("vector not loaded ten cycles after acknowledge");
   jump_time_a: assert property (fetchLoad |-> ##5 handlerStart)
      else $error("handler not started five cycles after vector load");
   vec_slot_a: assert property (fetchLoad |-> fetchAddr inside {13'h0002, 13'h0004,
      13'h0006, 13'h0008, 13'h000a, 13'h000c, 13'h0014, 13'h0016})
      else $error("vector address outside the used slots");
   return_from_irq_instr_restore_a: assert property (returnFromIrqInstr |=> restoreValid && irqEnabled)
      else $error("return did not restore frame and enable");
   ei_nest_a: assert property (enableIrqsInstr |=> irqEnabled || stackPush)
      else $error("enable instruction did not set the global enable");
endmodule : uic_irq_ctrl_sva

/* File: uic_pkg.sv */
// Shared constants and types for the interrupt controller
package uic_pkg;

   // ===================================================================
   // Timing
   localparam int unsigned CLK_PERIOD_NS  = 8;
   localparam int unsigned BUSRST_MIN_NS  = 8000;
   localparam int unsigned BUSRST_CYC     = (BUSRST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned CALL_CYC       = 10;
   localparam int unsigned JMP_CYC        = 5;

   // ===================================================================
   // Register indices; byte address is four times the index
   localparam logic [7:0] REG_GLOBAL_IE_IDX = 8'h20;
   localparam logic [7:0] REG_EP_IE_IDX     = 8'h21;
   localparam logic [7:0] REG_DAC_IE_IDX    = 8'h30;
   localparam logic [7:0] REG_DAC_POL_IDX   = 8'h31;
   localparam logic [7:0] REG_GPIO_IE_IDX   = 8'h32;
   localparam logic [7:0] REG_GPIO_POL_IDX  = 8'h33;
   localparam logic [7:0] REG_PENDING_IDX   = 8'h34;
   localparam logic [7:0] REG_STATUS_IDX    = 8'hff;

   // ===================================================================
   // Field positions and reset values
   localparam int unsigned GIE_BUSRST_BIT  = 0;
   localparam int unsigned GIE_T128_BIT    = 1;
   localparam int unsigned GIE_T1024_BIT   = 2;
   localparam int unsigned GIE_DAC_BIT     = 3;
   localparam int unsigned GIE_GPIO_BIT    = 4;
   localparam int unsigned GIE_W           = 5;
   localparam int unsigned EP_IE_W         = 3;
   localparam int unsigned STAT_PEND_BIT   = 7;
   localparam int unsigned STAT_BUSRST_BIT = 5;
   localparam int unsigned STAT_IE_BIT     = 2;
   localparam logic [4:0]  GIE_RST         = 5'h00;
   localparam logic [2:0]  EP_IE_RST       = 3'h0;
   localparam logic [31:0] PIN_IE_RST      = 32'h0000_0000;
   localparam logic [31:0] PIN_POL_RST     = 32'h0000_0000;

   // ===================================================================
   // Vector numbers; address is number times the slot size
   localparam int unsigned PC_W         = 13;
   localparam int unsigned VEC_N        = 12;
   localparam int unsigned VEC_STRIDE   = 2;
   localparam logic [12:0] RESET_VECTOR = 13'h0000;
   localparam int unsigned VN_BUSRST    = 1;
   localparam int unsigned VN_T128      = 2;
   localparam int unsigned VN_T1024     = 3;
   localparam int unsigned VN_EP0       = 4;
   localparam int unsigned VN_DAC       = 10;
   localparam int unsigned VN_GPIO      = 11;

   typedef struct packed {
      logic [PC_W-1:0] pc;
      logic            carryFlag;
      logic            zeroFlag;
   } uic_frame_t;

   typedef enum logic [1:0] {SEQ_IDLE, SEQ_CALL, SEQ_JUMP} uic_seq_t;

   function automatic logic [11:0] regAddr(input logic [7:0] idx);
      regAddr = {2'b00, idx, 2'b00};
   endfunction : regAddr

endpackage : uic_pkg

/* File: usb_mcu_interrupt_controller_tb.sv */
// Self-checking bench for the interrupt controller
`timescale 1ns/1ps
module usb_mcu_interrupt_controller_tb;
   logic                sys_clk, nrst, psel, penable, pwrite, pready, pslverr, retReq;
   logic                usbDp, usbDm, tick128us, tick1024us, instrLast, carryFlag, zeroFlag;
   logic                enableIrqsInstr, disableIrqsInstr, returnFromIrqInstr, irqEnabled;
   logic                seqBusy, stackPush, fetchLoad, handlerStart, restoreValid;
   logic [2:0]          epPacketDone;
   logic [7:0]          dacPins;
   logic [11:0]         paddr;
   logic [12:0]         pcNow, fetchAddr;
   logic [31:0]         pwdata, prdata, gpioPins;
   logic [32:0]         rdQ[$];
   logic [12:0]         vecQ[$];
   uic_pkg::uic_frame_t stackPopFrame, stackPushFrame, restoreFrame, ackFrame, lastPop;
   int                  fails, nTests, i, k;

   uic_irq_ctrl dut (.sys_clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .usbDp, .usbDm, .tick128us, .tick1024us, .epPacketDone, .dacPins,
      .gpioPins, .instrLast, .enableIrqsInstr, .disableIrqsInstr, .returnFromIrqInstr,
      .pcNow, .carryFlag, .zeroFlag, .stackPopFrame, .seqBusy, .stackPush, .stackPushFrame,
      .fetchAddr, .fetchLoad, .handlerStart, .restoreValid, .restoreFrame, .irqEnabled);
   uic_core_model core (.sys_clk, .nrst, .seqBusy, .stackPush, .retReq, .instrLast, .pcNow,
      .carryFlag, .zeroFlag, .returnFromIrqInstr, .stackPopFrame, .ackFrame, .lastPop);

   // ==================================================================
   // Comparison and closing
   task automatic tally(input logic ok, input string what);
      nTests++;
      if (ok !== 1'b1) begin
         fails++;
         $display("CHECK FAILED %0t %s", $time, what);
      end
   endtask : tally
   task automatic chkRd(input logic [32:0] got, input logic [32:0] exp);
      tally(got === exp, $sformatf("read %h, want %h", got, exp));
   endtask : chkRd
   task automatic chkVec(input logic [12:0] got, input logic [12:0] exp);
      tally(got === exp, $sformatf("vector %h, want %h", got, exp));
   endtask : chkVec
   task automatic chkFrame(input uic_pkg::uic_frame_t got, input uic_pkg::uic_frame_t exp);
      tally(got === exp, $sformatf("frame %h, want %h", got, exp));
   endtask : chkFrame
   task automatic end_sim;
      $display("Comparisons %0d, mismatches %0d", nTests, fails);
      if (fails == 0 && nTests > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : end_sim

   // ==================================================================
   // Drivers
   task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] d,
                      input logic [32:0] exp);
      @(posedge sys_clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= {2'b00, idx, 2'b00};
      pwdata  <= d;
      if (!wr) rdQ.push_back(exp);
      @(posedge sys_clk);
      penable <= 1'b1;
      do @(posedge sys_clk); while (pready !== 1'b1);
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wr(input logic [7:0] idx, input logic [31:0] d);
      apb(1'b1, idx, d, 33'h0);
   endtask : wr
   task automatic rd(input logic [7:0] idx, input logic [31:0] d);
      apb(1'b0, idx, 32'h0, {1'b0, d});
   endtask : rd
   // Pulse bits: 6 disable, 5 enable, 4..2 endpoints, 1 slow tick, 0 fast tick
   task automatic fire(input logic [6:0] s);
      @(posedge sys_clk);
      {disableIrqsInstr, enableIrqsInstr, epPacketDone, tick1024us, tick128us} <= s;
      @(posedge sys_clk);
      {disableIrqsInstr, enableIrqsInstr, epPacketDone, tick1024us, tick128us} <= 7'h00;
   endtask : fire
   // Waits for the handler, then returns from it
   task automatic waitH;
      for (i = 0; i < 80 && handlerStart !== 1'b1; i++) @(posedge sys_clk);
      tally(handlerStart === 1'b1, "handler never started");
      retReq <= 1'b1;
      @(posedge sys_clk);
      retReq <= 1'b0;
      repeat (3) @(posedge sys_clk);
   endtask : waitH
   task automatic svc(input logic [12:0] v);
      vecQ.push_back(v);
      waitH;
   endtask : svc

   // Any vector load with no expectation queued is a failure
   always @(posedge sys_clk) begin
      if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && !pwrite && rdQ.size() > 0)
         chkRd({pslverr, prdata}, rdQ.pop_front());
      if (fetchLoad === 1'b1) chkVec(fetchAddr, vecQ.size() > 0 ? vecQ.pop_front() : 13'h1fff);
      if (stackPush === 1'b1) chkFrame(stackPushFrame, ackFrame);
      if (restoreValid === 1'b1) chkFrame(restoreFrame, lastPop);
   end

   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end
   initial begin
      repeat (20000) @(posedge sys_clk);
      fails++;
      end_sim;
   end

   // ==================================================================
   // Scenarios
   initial begin
      void'($urandom(39875));
      {psel, penable, pwrite, retReq, usbDp, tick128us, tick1024us, disableIrqsInstr} = '0;
      {enableIrqsInstr, epPacketDone, dacPins, gpioPins, paddr, pwdata} = '0;
      usbDm = 1'b1;
      nrst  = 1'b0;
      repeat (4) @(posedge sys_clk);
      nrst <= 1'b1;
      chkVec(fetchAddr, 13'h0000);
      rd(uic_pkg::REG_GLOBAL_IE_IDX, 32'h0);
      rd(uic_pkg::REG_EP_IE_IDX, 32'h0);
      apb(1'b0, 8'h40, 32'h0, {1'b1, 32'h0});
      wr(uic_pkg::REG_EP_IE_IDX, 32'hff);
      rd(uic_pkg::REG_EP_IE_IDX, 32'h7);
      wr(uic_pkg::REG_GLOBAL_IE_IDX, 32'h1f);
      fire(7'h20);
      wr(uic_pkg::REG_STATUS_IDX, 32'h0);
      rd(uic_pkg::REG_STATUS_IDX, 32'h4);
      fire(7'h01);
      svc(13'h0004);
      for (k = 0; k < 3; k++) begin
         fire(7'h04 << k);
         svc(13'h0008 + 13'(2 * k));
      end
      fire(7'h40);
      fire(7'h06);
      rd(uic_pkg::REG_STATUS_IDX, 32'h80);
      fire(7'h20);
      vecQ.push_back(13'h0006);
      svc(13'h0008);
      waitH;
      usbDm <= 1'b0;
      repeat (900) @(posedge sys_clk);
      usbDm <= 1'b1;
      @(posedge sys_clk);
      usbDm <= 1'b0;
      vecQ.push_back(13'h0002);
      repeat (990) @(posedge sys_clk);
      waitH;
      usbDm <= 1'b1;
      wr(uic_pkg::REG_DAC_POL_IDX, 32'h3);
      wr(uic_pkg::REG_DAC_IE_IDX, 32'h3);
      dacPins <= 8'h01;
      svc(13'h0014);
      dacPins <= 8'h03;
      repeat (40) @(posedge sys_clk);
      dacPins <= 8'h00;
      @(posedge sys_clk);
      dacPins <= 8'h02;
      svc(13'h0014);
      rd(uic_pkg::REG_DAC_IE_IDX, 32'h3);
      wr(uic_pkg::REG_GPIO_POL_IDX, 32'hf);
      wr(uic_pkg::REG_GPIO_IE_IDX, 32'hffff_ffff);
      gpioPins <= 32'h1 << ($urandom % 32);
      svc(13'h0016);
      rd(uic_pkg::REG_GPIO_IE_IDX, 32'hffff_ffff);
      wr(uic_pkg::REG_GLOBAL_IE_IDX, 32'h19);
      fire(7'h03);
      wr(uic_pkg::REG_EP_IE_IDX, 32'h3);
      fire(7'h10);
      repeat (40) @(posedge sys_clk);
      rd(uic_pkg::REG_EP_IE_IDX, 32'h3);
      end_sim;
   end
endmodule : usb_mcu_interrupt_controller_tb

bind uic_irq_ctrl uic_irq_ctrl_sva chk (.sys_clk, .nrst, .instrLast, .enableIrqsInstr,
   .returnFromIrqInstr, .seqBusy, .stackPush, .fetchAddr, .fetchLoad, .handlerStart,
   .restoreValid, .irqEnabled);
